// ---- hdl/adc_sweep_pga_control.sv ----
// Converter control: gain decode, manual and sweep conversion, sample buffers, pin mux.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "adc_sweep_params.svh"

// Function
// - Ten converter inputs across eight channel slots.
// - Gain 0 to 42 dB, 3 dB steps.
// - Single-ended amp ties other input to common-mode.
// - Reset leaves manual single-channel mode.
// - Manual rate 80k, 160k or 320k.
// - Manual differential or single-ended; differential default.
// - Manual mode samples continuously into channel buffer.
// - 256-byte buffer window per channel; full sets flag.
// - One 32-bit word per result, sixty-four results.
// - Override cleared starts automatic sweep.
// - Sweep uses same per-channel buffers.
// - Per-channel time, enable, differential, one-shot field.
// - Sample time 2..62 or 3..63 periods.
// - Two channel fields per word, low first.
// - Pin mux pass and attenuation bits.
module adc_sweep_pga_control
    import adc_sweep_pkg::*;
#(
    parameter int BUF_DEPTH = 64,
    parameter int RES_W     = 12
) (
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_I,
    input  wire logic             CE_I,
    input  wire logic [31:0]      ADDR_I,
    input  wire logic [31:0]      WR_DATA_I,
    input  wire logic             WR_I,
    input  wire logic             RD_I,
    input  wire logic             CONV_DONE_I,
    input  wire logic [RES_W-1:0] CONV_DATA_I,
    output logic      [31:0]      RD_DATA_O,
    output logic                  CONV_START_O,
    output logic      [2:0]       CONV_CHAN_O,
    output logic                  CONV_DIFF_O,
    output logic                  CONV_SE_NEG_O,
    output logic      [1:0]       STAGE1_GAIN_SEL_O,
    output logic      [2:0]       STAGE2_GAIN_SEL_O,
    output logic      [5:0]       AMP_GAIN_DB_O,
    output logic                  AMP_SINGLE_END_EN_O,
    output logic      [5:0]       PIN_PASS_O,
    output logic      [5:0]       PIN_ATTN_O,
    output logic                  IRQ_O
);

    localparam int NCH   = `NUM_CHAN;
    localparam int PTR_W = $clog2(BUF_DEPTH);
    localparam int IDX_W = PTR_W + 3;
    localparam int BUF_W = NCH * BUF_DEPTH;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Next eligible slot after the current one, wrapping round; current if none.
    function automatic logic [2:0] next_chan(input logic [7:0] mask, input logic [2:0] cur);
        logic [2:0] res;
        logic       found;
        logic [2:0] k;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= NCH; i++) begin
            k = 3'(cur + 3'(i));
            if (!found && mask[k]) begin
                res   = k;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_chan

    // Total amplifier gain in dB from the two stage codes.
    function automatic logic [5:0] gain_db(input logic [1:0] s1, input logic [2:0] s2);
        return 6'(s1 * `STAGE1_STEP_DB) + 6'(s2 * `STAGE2_STEP_DB);
    endfunction : gain_db

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    logic [31:0]      cfg_ff [0:3];
    logic [31:0]      ctrl_ff;
    logic [31:0]      amp_ff;
    logic [31:0]      pin_mux_ff;
    logic [7:0]       irq_stat_ff;
    logic [7:0]       irq_mask_ff;
    logic [7:0]       shot_done_ff;
    logic [PTR_W-1:0] wr_ptr_ff [0:NCH-1];
    logic [RES_W-1:0] buf_mem [0:BUF_W-1];
    ctl_state_e       state_ff;
    ctl_state_e       nxt_state;
    logic [2:0]       cur_ch_ff;
    logic             auto_ff;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [31:0]      buf_off;
    logic             sel_buf;
    logic [IDX_W-1:0] buf_idx;
    logic             sel_cfg;
    logic [1:0]       cfg_idx;
    logic             sel_ctrl;
    logic             sel_amp;
    logic             sel_pin;
    logic             sel_stat;
    logic             sel_mask;
    logic             sel_state;

    assign buf_off   = ADDR_I - `BUF_BASE;
    assign sel_buf   = (ADDR_I >= `BUF_BASE) && (buf_off < 32'(BUF_W * 4));
    assign buf_idx   = buf_off[IDX_W+1:2];
    assign sel_cfg   = (ADDR_I >= `OFS_CFG_AMP_TEMP) && (ADDR_I <= `OFS_CFG_PAIR_C)
                       && (ADDR_I[1:0] == 2'h0);
    assign cfg_idx   = ADDR_I[3:2] + 2'h1;
    assign sel_ctrl  = (ADDR_I == `OFS_CTRL);
    assign sel_amp   = (ADDR_I == `OFS_AMP);
    assign sel_pin   = (ADDR_I == `OFS_PIN_MUX);
    assign sel_stat  = (ADDR_I == `OFS_IRQ_STAT);
    assign sel_mask  = (ADDR_I == `OFS_IRQ_MASK);
    assign sel_state = (ADDR_I == `OFS_STATE);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Per-channel configuration fields, low half first in each word.

    logic [7:0]       ch_en;
    logic [7:0]       ch_diff;
    logic [7:0]       ch_shot;
    logic [3:0]       ch_stime [0:NCH-1];

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_cfg
            localparam int BASE = (g % 2) * `CFG_FIELD_W;
            assign ch_stime[g] = cfg_ff[g/2][BASE + `CFG_STIME_LSB +: 4];
            assign ch_en[g]    = cfg_ff[g/2][BASE + `CFG_EN_BIT];
            assign ch_diff[g]  = cfg_ff[g/2][BASE + `CFG_DIFF_BIT];
            assign ch_shot[g]  = cfg_ff[g/2][BASE + `CFG_ONESHOT_BIT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // Control fields and mode.

    logic             man_ovr;
    logic             man_run;
    logic [1:0]       man_rate;
    logic [1:0]       man_se;
    logic [2:0]       man_ch;
    logic             max256;
    logic             want_auto;
    logic             active;
    logic [7:0]       eligible;
    logic [2:0]       auto_ch;

    assign man_ovr   = ctrl_ff[`CTRL_OVR_BIT];
    assign man_run   = ctrl_ff[`CTRL_RUN_BIT];
    assign man_rate  = ctrl_ff[`CTRL_RATE_LSB +: 2];
    assign man_se    = ctrl_ff[`CTRL_SE_LSB +: 2];
    assign man_ch    = ctrl_ff[`CTRL_CHAN_LSB +: 3];
    assign max256    = ctrl_ff[`CTRL_MAX256_BIT];
    assign want_auto = !man_ovr;
    assign active    = want_auto ? (|eligible) : man_run;
    assign eligible  = ch_en & ~shot_done_ff;
    assign auto_ch   = next_chan(eligible, cur_ch_ff);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Window length in 1.28 MHz periods for the next sample.

    logic [2:0]       pick_ch;
    logic [5:0]       man_len;
    logic [5:0]       auto_len;
    logic [5:0]       win_len;
    logic             pick_diff;
    logic             pick_neg;

    assign pick_ch  = want_auto ? auto_ch : man_ch;
    assign man_len  = (man_rate == RATE_80K)  ? 6'(`RATE_80K_TICKS)  :
                      (man_rate == RATE_160K) ? 6'(`RATE_160K_TICKS) :
                                                6'(`RATE_320K_TICKS);
    assign auto_len = {ch_stime[auto_ch], 2'h0}
                      + (max256 ? `STIME_BASE_256 : `STIME_BASE_320);
    assign win_len  = want_auto ? auto_len : man_len;
    // Odd slots above the temperature pair are the negative inputs.
    assign pick_diff = want_auto ? ch_diff[auto_ch] : (man_se == SE_DIFF);
    assign pick_neg  = want_auto ? (!ch_diff[auto_ch] && auto_ch[0] && (auto_ch > 3'h1))
                                 : (man_se == SE_NEG);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sample window timer.

    logic             tmr_load;
    logic             tmr_expire;

    assign tmr_load = (state_ff == ST_IDLE) && active;

    sample_timer u_timer (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .ce_i     (CE_I),
        .load_i   (tmr_load),
        .len_i    (win_len),
        .expire_o (tmr_expire)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer: idle, sample window, conversion.

    logic             mode_change;
    logic             store;
    logic             buf_full_evt;

    assign mode_change  = (auto_ff != want_auto) || !active;
    assign store        = (state_ff == ST_CONVERT) && CONV_DONE_I;
    assign buf_full_evt = store && (wr_ptr_ff[cur_ch_ff] == PTR_W'(BUF_DEPTH - 1));

    // Next-state choice; a conversion in flight always completes.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:    if (active) nxt_state = ST_SAMPLE;
            ST_SAMPLE:  if (mode_change) nxt_state = ST_IDLE;
                        else if (tmr_expire) nxt_state = ST_CONVERT;
            ST_CONVERT: if (CONV_DONE_I) nxt_state = ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
    end

    // State, channel latch and converter request outputs.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff      <= ST_IDLE;
            cur_ch_ff     <= 3'h0;
            auto_ff       <= 1'b0;
            CONV_START_O  <= 1'b0;
            CONV_CHAN_O   <= 3'h0;
            CONV_DIFF_O   <= 1'b1;
            CONV_SE_NEG_O <= 1'b0;
        end else if (CE_I) begin
            state_ff     <= nxt_state;
            CONV_START_O <= (state_ff == ST_SAMPLE) && !mode_change && tmr_expire;
            if (tmr_load) begin
                cur_ch_ff     <= pick_ch;
                auto_ff       <= want_auto;
                CONV_CHAN_O   <= pick_ch;
                CONV_DIFF_O   <= pick_diff;
                CONV_SE_NEG_O <= pick_neg;
            end
        end
    end

    // One-shot bookkeeping; cleared whenever software holds manual mode.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            shot_done_ff <= 8'h00;
        end else if (CE_I) begin
            if (man_ovr) begin
                shot_done_ff <= 8'h00;
            end else if (store && auto_ff && ch_shot[cur_ch_ff]) begin
                shot_done_ff[cur_ch_ff] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sample buffers: one slot of BUF_DEPTH results per channel, wrapping.

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ptr
            always_ff @(posedge REF_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    wr_ptr_ff[g] <= '0;
                end else if (CE_I && store && (cur_ch_ff == 3'(g))) begin
                    wr_ptr_ff[g] <= wr_ptr_ff[g] + 1'b1;
                end
            end
        end
    endgenerate

    // Result store; both modes share the same per-channel region.
    always_ff @(posedge REF_CLK_I) begin
        if (CE_I && store) begin
            buf_mem[{cur_ch_ff, wr_ptr_ff[cur_ch_ff]}] <= CONV_DATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register writes.

    logic             wr_cfg;

    assign wr_cfg = WR_I && sel_cfg;

    // Configuration words; undefined bits are not kept.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < 4; i++) cfg_ff[i] <= `CFG_RESET;
        end else if (CE_I && wr_cfg) begin
            cfg_ff[cfg_idx] <= WR_DATA_I & `CFG_MASK;
        end
    end

    // Control, amplifier, pin mux and interrupt mask registers.
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_ff     <= `CTRL_RESET;
            amp_ff      <= `AMP_RESET;
            pin_mux_ff  <= `PIN_MUX_RESET;
            irq_mask_ff <= 8'h00;
        end else if (CE_I && WR_I) begin
            if (sel_ctrl) ctrl_ff <= WR_DATA_I & `CTRL_MASK;
            if (sel_amp)  amp_ff  <= WR_DATA_I & `AMP_MASK;
            if (sel_pin)  pin_mux_ff <= WR_DATA_I & `PIN_MUX_MASK;
            if (sel_mask) irq_mask_ff <= WR_DATA_I[7:0];
        end
    end

    // Sticky buffer-full flags; a new event beats a clear in the same cycle.
    logic [7:0]       full_set;
    logic [7:0]       stat_clr;

    assign full_set = buf_full_evt ? (8'h01 << cur_ch_ff) : 8'h00;
    assign stat_clr = (WR_I && sel_stat) ? WR_DATA_I[7:0] : 8'h00;

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_stat_ff <= 8'h00;
            IRQ_O       <= 1'b0;
        end else if (CE_I) begin
            irq_stat_ff <= (irq_stat_ff & ~stat_clr) | full_set;
            IRQ_O       <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Amplifier and pin mux outputs.

    logic [1:0]       s1_code;
    logic [2:0]       s2_code;

    // Out-of-table codes are held at the top documented step.
    assign s1_code = (amp_ff[`AMP_S1_LSB +: 2] > `STAGE1_MAX_CODE) ? `STAGE1_MAX_CODE
                                                                  : amp_ff[`AMP_S1_LSB +: 2];
    assign s2_code = (amp_ff[`AMP_S2_LSB +: 3] > `STAGE2_MAX_CODE) ? `STAGE2_MAX_CODE
                                                                  : amp_ff[`AMP_S2_LSB +: 3];

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            STAGE1_GAIN_SEL_O   <= 2'h0;
            STAGE2_GAIN_SEL_O   <= 3'h0;
            AMP_GAIN_DB_O       <= 6'h00;
            AMP_SINGLE_END_EN_O <= 1'b0;
            PIN_PASS_O          <= 6'h00;
            PIN_ATTN_O          <= 6'h00;
        end else if (CE_I) begin
            STAGE1_GAIN_SEL_O   <= s1_code;
            STAGE2_GAIN_SEL_O   <= s2_code;
            AMP_GAIN_DB_O       <= gain_db(s1_code, s2_code);
            AMP_SINGLE_END_EN_O <= amp_ff[`AMP_SE_BIT];
            PIN_PASS_O          <= pin_mux_ff[`PIN_PASS_LSB +: 6];
            PIN_ATTN_O          <= pin_mux_ff[`PIN_ATTN_LSB +: 6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read path: data stands in the cycle after the strobe; unmapped reads zero.

    logic [31:0]      state_word;
    logic [31:0]      rd_mux;

    assign state_word = {16'h0000, shot_done_ff, 3'h0, auto_ff,
                         (state_ff != ST_IDLE), cur_ch_ff};
    assign rd_mux = sel_buf   ? 32'(buf_mem[buf_idx]) :
                    sel_cfg   ? cfg_ff[cfg_idx]       :
                    sel_ctrl  ? ctrl_ff               :
                    sel_amp   ? amp_ff                :
                    sel_pin   ? pin_mux_ff            :
                    sel_stat  ? {24'h000000, irq_stat_ff} :
                    sel_mask  ? {24'h000000, irq_mask_ff} :
                    sel_state ? state_word            : 32'h0000_0000;

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RD_DATA_O <= 32'h0000_0000;
        end else if (CE_I) begin
            RD_DATA_O <= RD_I ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : adc_sweep_pga_control

// ---- hdl/adc_sweep_params.svh ----
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ADC_SWEEP_PARAMS_SVH
`define ADC_SWEEP_PARAMS_SVH

// Register byte addresses.
`define OFS_PIN_MUX       32'h4000_F020
`define OFS_CFG_AMP_TEMP  32'h4000_F06C
`define OFS_CFG_PAIR_A    32'h4000_F070
`define OFS_CFG_PAIR_B    32'h4000_F074
`define OFS_CFG_PAIR_C    32'h4000_F078
`define OFS_CTRL          32'h4000_F080
`define OFS_AMP           32'h4000_F084
`define OFS_IRQ_STAT      32'h4000_F088
`define OFS_IRQ_MASK      32'h4000_F08C
`define OFS_STATE         32'h4000_F090
`define BUF_BASE          32'h4000_F400

// Channel configuration field layout, two fields per word.
`define NUM_CHAN          8
`define CFG_FIELD_W       16
`define CFG_STIME_LSB     0
`define CFG_EN_BIT        4
`define CFG_DIFF_BIT      5
`define CFG_ONESHOT_BIT   6
`define CFG_MASK          32'h007F_007F
`define CFG_RESET         32'h0000_0000

// Analog pin mux layout.
`define PIN_PASS_LSB      0
`define PIN_ATTN_LSB      8
`define PIN_MUX_MASK      32'h0000_3F3F
`define PIN_MUX_RESET     32'h0000_0000

// Control register layout; reset leaves the manual override set.
`define CTRL_OVR_BIT      0
`define CTRL_RUN_BIT      1
`define CTRL_RATE_LSB     2
`define CTRL_SE_LSB       4
`define CTRL_CHAN_LSB     6
`define CTRL_MAX256_BIT   9
`define CTRL_MASK         32'h0000_03FF
`define CTRL_RESET        32'h0000_0001

// Amplifier register layout.
`define AMP_S1_LSB        0
`define AMP_S2_LSB        2
`define AMP_SE_BIT        5
`define AMP_MASK          32'h0000_003F
`define AMP_RESET         32'h0000_0000
`define STAGE1_STEP_DB    6'h0C
`define STAGE2_STEP_DB    6'h03
`define STAGE1_MAX_CODE   2'h2
`define STAGE2_MAX_CODE   3'h6

// Timing: reference and sample clock rates in Hz, derived tick counts.
`define REF_CLK_HZ        100_000_000
`define SAMPLE_CLK_HZ     1_280_000
`define TICK_GCD          10_000
`define TICK_STEP         (`SAMPLE_CLK_HZ / `TICK_GCD)
`define TICK_MOD          (`REF_CLK_HZ / `TICK_GCD)
`define RATE_320K_HZ      320_000
`define RATE_160K_HZ      160_000
`define RATE_80K_HZ       80_000
`define RATE_320K_TICKS   (`SAMPLE_CLK_HZ / `RATE_320K_HZ)
`define RATE_160K_TICKS   (`SAMPLE_CLK_HZ / `RATE_160K_HZ)
`define RATE_80K_TICKS    (`SAMPLE_CLK_HZ / `RATE_80K_HZ)
`define STIME_BASE_320    6'h02
`define STIME_BASE_256    6'h03

`endif

// ---- hdl/adc_sweep_pkg.sv ----
// Types shared by the converter control modules.
package adc_sweep_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_SAMPLE  = 3'h2,
        ST_CONVERT = 3'h4
    } ctl_state_e;

    typedef enum logic [1:0] {
        RATE_80K  = 2'h0,
        RATE_160K = 2'h1,
        RATE_320K = 2'h2
    } rate_sel_e;

    typedef enum logic [1:0] {
        SE_DIFF = 2'h0,
        SE_POS  = 2'h1,
        SE_NEG  = 2'h2
    } se_mode_e;

endpackage : adc_sweep_pkg

// ---- hdl/sample_timer.sv ----
// Derives the 1.28 MHz sample tick and times one sample window in ticks.
`timescale 1ns/1ps
`include "adc_sweep_params.svh"

module sample_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       load_i,
    input  wire logic [5:0] len_i,
    output logic            expire_o
);

    localparam logic [13:0] STEP = 14'(`TICK_STEP);
    localparam logic [13:0] MODV = 14'(`TICK_MOD);

    logic [13:0] acc_ff;
    logic [5:0]  cnt_ff;
    logic [13:0] acc_sum;
    logic        tick;
    logic [13:0] nxt_acc;

    // Fractional accumulator gives an average tick rate of exactly 1.28 MHz.
    assign acc_sum = acc_ff + STEP;
    assign tick    = (acc_sum >= MODV);
    assign nxt_acc = tick ? (acc_sum - MODV) : acc_sum;

    // Counts ticks down from the loaded length; expires on the last one.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_ff   <= 14'h0000;
            cnt_ff   <= 6'h00;
            expire_o <= 1'b0;
        end else if (ce_i) begin
            acc_ff   <= nxt_acc;
            expire_o <= 1'b0;
            if (load_i) begin
                cnt_ff <= len_i;
            end else if (tick && (cnt_ff != 6'h00)) begin
                cnt_ff   <= cnt_ff - 6'h01;
                expire_o <= (cnt_ff == 6'h01);
            end
        end
    end

endmodule : sample_timer

// ---- tb/adc_sweep_chk.sv ----
// Port checker for the converter control.
`timescale 1ns/1ps
`include "adc_sweep_params.svh"
module adc_sweep_chk (
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    input wire logic        CE_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic        WR_I,
    input wire logic        CONV_START_O,
    input wire logic [2:0]  CONV_CHAN_O,
    input wire logic        CONV_DIFF_O,
    input wire logic [1:0]  STAGE1_GAIN_SEL_O,
    input wire logic [2:0]  STAGE2_GAIN_SEL_O,
    input wire logic [5:0]  AMP_GAIN_DB_O,
    input wire logic        AMP_SINGLE_END_EN_O,
    input wire logic [5:0]  PIN_PASS_O,
    input wire logic [5:0]  PIN_ATTN_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    //////////////////////////////////////////////////////////////////////////////////
    // Gain codes, total gain and the amplifier and pin mux registers.
    gain_sum_a: assert property ($stable(STAGE1_GAIN_SEL_O) && $stable(STAGE2_GAIN_SEL_O) |->
        AMP_GAIN_DB_O == {4'h0, STAGE1_GAIN_SEL_O} * 6'h0C + {3'h0, STAGE2_GAIN_SEL_O} * 6'h03)
        else $error("total gain differs from stage codes");
    gain_range_a: assert property (STAGE1_GAIN_SEL_O <= 2'h2 && STAGE2_GAIN_SEL_O <= 3'h6)
        else $error("gain code out of range");
    amp_write_a: assert property (WR_I && CE_I && ADDR_I == `OFS_AMP && WR_DATA_I[1:0] <= 2'h2
        && WR_DATA_I[4:2] <= 3'h6 |-> ##[1:2] {STAGE2_GAIN_SEL_O, STAGE1_GAIN_SEL_O,
        AMP_SINGLE_END_EN_O} == {$past(WR_DATA_I[4:0], 2), $past(WR_DATA_I[5], 2)})
        else $error("amplifier write not applied");
    pin_write_a: assert property (WR_I && CE_I && ADDR_I == `OFS_PIN_MUX |=> ##1
        {PIN_ATTN_O, PIN_PASS_O} == {$past(WR_DATA_I[13:8], 2), $past(WR_DATA_I[5:0], 2)})
        else $error("pin mux write not applied");
    // Conversion start pulse, channel hold and differential mode after reset.
    start_pulse_a: assert property (CONV_START_O |=> !CONV_START_O)
        else $error("start pulse longer than one cycle");
    start_gap_a: assert property ($rose(CONV_START_O) |=> !CONV_START_O [*8])
        else $error("starts closer than a sample window");
    chan_hold_a: assert property (CONV_START_O |-> $stable(CONV_CHAN_O))
        else $error("channel moved at conversion start");
    reset_diff_a: assert property ($fell(RST_I) |-> CONV_DIFF_O)
        else $error("not differential after reset");
endmodule : adc_sweep_chk

// ---- tb/conv_model.sv ----
// Behavioural converter core answering each start pulse with a tagged result.
`timescale 1ns/1ps
module conv_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [2:0] chan_i,
    output logic            done_o,
    output logic [11:0]     data_o
);
    logic [2:0] cnt_ff;
    // Result arrives five cycles after start; data churns while not valid.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 3'h0;
            done_o <= 1'b0;
            data_o <= 12'h000;
        end else begin
            done_o <= (cnt_ff == 3'h1);
            data_o <= (cnt_ff == 3'h1) ? {9'h100, chan_i} : ~data_o;
            cnt_ff <= start_i ? 3'h4 : cnt_ff - {2'h0, cnt_ff != 3'h0};
        end
    end
endmodule : conv_model

// ---- tb/testbench.sv ----
// Self-checking bench for the converter control.
`timescale 1ns/1ps
`include "adc_sweep_params.svh"
module testbench;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done, start, diff, neg, se, irq;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
    logic [11:0] cdata;
    logic [5:0]  db, pass, attn;
    logic [2:0]  chan, s2;
    logic [1:0]  s1;
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    adc_sweep_pga_control dut_u (.REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .ADDR_I(addr),
        .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .CONV_DONE_I(done), .CONV_DATA_I(cdata),
        .RD_DATA_O(rdata), .CONV_START_O(start), .CONV_CHAN_O(chan), .CONV_DIFF_O(diff),
        .CONV_SE_NEG_O(neg), .STAGE1_GAIN_SEL_O(s1), .STAGE2_GAIN_SEL_O(s2),
        .AMP_GAIN_DB_O(db), .AMP_SINGLE_END_EN_O(se), .PIN_PASS_O(pass),
        .PIN_ATTN_O(attn), .IRQ_O(irq));
    conv_model core_u (.clk_i(clk), .rst_i(rst), .start_i(start), .chan_i(chan),
        .done_o(done), .data_o(cdata));
    //////////////////////////////////////////////////////////////////////////////////
    // Clock and a hang limit well above the longest expected run.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [31:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask : rd_reg
    task automatic wait_start(output int t);
        int i;
        @(negedge clk);
        for (i = 0; i < 2000 && start !== 1'b1; i++) @(negedge clk);
        t = cyc;
        chk("start", 32'h1, {31'h0, start});
    endtask : wait_start
    //////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_gain;
        for (int a = 0; a < 3; a++) for (int b = 0; b < 7; b++) begin
            wr_reg(`OFS_AMP, 32'(a + b * 4 + (b % 2) * 32));
            repeat (3) @(negedge clk);
            chk("gain", 32'(12 * a + 3 * b), {26'h0, db});
            chk("single", 32'(b % 2), {31'h0, se});
        end
    endtask : t_gain
    task automatic t_pins;
        wr_reg(`OFS_PIN_MUX, 32'h0000_2A15);
        repeat (3) @(negedge clk);
        chk("pins", 32'h0000_2A15, {18'h0, attn, 2'h0, pass});
        rd_reg(`OFS_PIN_MUX, 32'h0000_2A15, "pinmux");
        rd_reg(32'h4000_F0FC, 32'h0, "unmapped");
    endtask : t_pins
    task automatic t_manual;
        int ta, tb, i;
        wr_reg(`OFS_IRQ_MASK, 32'h4);
        wr_reg(`OFS_CTRL, 32'h0000_00AB);
        wait_start(ta);
        wait_start(tb);
        chk("chan", 32'h5, {28'h0, chan, neg});
        chk("rate", 32'h1, 32'(tb - ta >= 300 && tb - ta <= 330));
        for (i = 0; i < 30000 && irq !== 1'b1; i++) @(negedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd_reg(`BUF_BASE + 32'h214, 32'h802, "buffer");
        wr_reg(`OFS_IRQ_MASK, 32'h0);
        repeat (3) @(negedge clk);
        chk("masked", 32'h0, {31'h0, irq});
        rd_reg(`OFS_IRQ_STAT, 32'h4, "status");
        wr_reg(`OFS_IRQ_STAT, 32'h4);
        rd_reg(`OFS_IRQ_STAT, 32'h0, "cleared");
    endtask : t_manual
    task automatic t_sweep;
        int t, t0;
        wr_reg(`OFS_CTRL, 32'h1);
        repeat (20) @(negedge clk);
        wr_reg(`OFS_CFG_PAIR_B, 32'h0010_0070);
        rd_reg(`OFS_CFG_PAIR_B, 32'h0010_0070, "cfg_b");
        wr_reg(`OFS_CTRL, 32'h200);
        wait_start(t);
        chk("first", 32'h9, {28'h0, chan, diff});
        for (int i = 0; i < 3; i++) begin
            t0 = t;
            wait_start(t);
            chk("next", 32'h15, {27'h0, chan, diff, neg});
            chk("win256", 32'h1, 32'(t - t0 > 200 && t - t0 < 250));
        end
        rd_reg(`BUF_BASE + 32'h500, 32'h805, "sweep_buf");
    endtask : t_sweep
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Main sequence: reset, register defaults, then each scenario.
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`OFS_CTRL, `CTRL_RESET, "ctrl");
        rd_reg(`OFS_CFG_PAIR_A, `CFG_RESET, "cfg");
        chk("diff", 32'h1, {31'h0, diff});
        t_gain();
        t_pins();
        t_manual();
        t_sweep();
        wrap_up();
    end
endmodule : testbench
bind adc_sweep_pga_control adc_sweep_chk chk_u (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .CE_I(CE_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I),
    .CONV_START_O(CONV_START_O), .CONV_CHAN_O(CONV_CHAN_O), .CONV_DIFF_O(CONV_DIFF_O),
    .STAGE1_GAIN_SEL_O(STAGE1_GAIN_SEL_O), .STAGE2_GAIN_SEL_O(STAGE2_GAIN_SEL_O),
    .AMP_GAIN_DB_O(AMP_GAIN_DB_O), .AMP_SINGLE_END_EN_O(AMP_SINGLE_END_EN_O),
    .PIN_PASS_O(PIN_PASS_O), .PIN_ATTN_O(PIN_ATTN_O));
